/* File: hw/fsp_pkg.sv */
// Constants for the flash self-program control block.
// Assumes one CPU clock domain and a separate flash array macro.
package fsp_pkg;

	// ****************************************
	// Control register field positions
	// ****************************************
	localparam int BIT_IRQ_EN  = 7;
	localparam int BIT_BUSY    = 6;
	localparam int BIT_RSVD    = 5;
	localparam int BIT_REEN    = 4;
	localparam int BIT_LOCK    = 3;
	localparam int BIT_PGWR    = 2;
	localparam int BIT_PGER    = 1;
	localparam int BIT_STEN    = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] EXT_RESET  = 8'h00;

	// ****************************************
	// Lower-five-bit command codes
	// ****************************************
	localparam logic [4:0] CMD_REEN  = 5'h11;
	localparam logic [4:0] CMD_LOCK  = 5'h09;
	localparam logic [4:0] CMD_PGWR  = 5'h05;
	localparam logic [4:0] CMD_PGER  = 5'h03;
	localparam logic [4:0] CMD_FILL  = 5'h01;

	// ****************************************
	// Timing
	// ****************************************
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW  = 3'h3;

	localparam logic [15:0] APP_RESET_WORD = 16'h0000;

	typedef enum logic [1:0]
	{
		FSP_IDLE  = 2'b00,
		FSP_ARMED = 2'b01,
		FSP_BUSY  = 2'b10,
		FSP_LOCKW = 2'b11
	} fsp_state_e;

endpackage : fsp_pkg

/* File: hw/fsp_window.sv */
// Arming window counter for store and load instructions.
// Assumes start is a one-cycle pulse from the control write decode.
module fsp_window
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       start,
	input  wire logic       stop,
	input  wire logic [2:0] length,
	// Status
	output logic            open_now
);

	logic [2:0] count;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			count <= 3'h0;
		else if (start)
			count <= length;
		else if (stop)
			count <= 3'h0;
		else if (count != 3'h0)
			count <= count - 3'h1;
	end

	assign open_now = (count != 3'h0);

endmodule : fsp_window

/* File: hw/fsp_control.sv */
// Flash self-program control: command register, pointer and sequencing.
// Assumes the CPU decodes its own store/load instructions into pulses and
// the flash macro reports completion with a done pulse.
//
// Function
// [RULE1] Reset vector chosen by boot vector fuse
// [RULE2] Processor cannot write any fuse
// [RULE3] Ready interrupt while store enable clear
// [RULE4] Section erase/write sets busy, blocks section
// [RULE5] Busy clears on reenable or buffer load
// [RULE6] Reenable needs store, not while busy
// [RULE7] Reenable during loading discards buffer
// [RULE8] Bit five reads zero
// [RULE9] Lock command programs lock from low reg
// [RULE10] Lock bit clears on done or timeout
// [RULE11] Load within three returns lock/fuse
// [RULE12] Page write from buffer to page
// [RULE13] Write clears on done; halt for halting section
// [RULE14] Page erase to pointer page
// [RULE15] Erase clears on done; halt for halting section
// [RULE16] Plain store fills buffer word
// [RULE17] Store enable arms four cycles
// [RULE18] Store enable high during erase/write
// [RULE19] Only five command patterns act
// [RULE20] Pointer has extension bit sixteen
// [RULE21] Target address latched at start
// [RULE22] Loads address bytes with byte select
// [RULE23] Software uses same page for erase/write
// [RULE24] Software waits before lock programming
module fsp_control
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Control register port
	input  wire logic        ctrl_wr,
	input  wire logic [7:0]  ctrl_wdata,
	output logic      [7:0]  self_program_control_status,
	input  wire logic        ext_wr,
	input  wire logic [7:0]  ext_wdata,
	output logic      [7:0]  program_pointer_extension,
	// CPU instruction side
	input  wire logic        global_irq_en,
	input  wire logic        store_program_instruction,
	input  wire logic        load_program_instruction,
	input  wire logic [7:0]  pointer_high,
	input  wire logic [7:0]  pointer_low,
	input  wire logic [7:0]  data_low_reg,
	input  wire logic [7:0]  data_high_reg,
	output logic             ready_irq,
	output logic             load_hit,
	output logic      [7:0]  load_data,
	output logic             cpu_halt,
	output logic             section_blocked,
	output logic      [15:0] reset_word,
	// Fuses and locks (fuses are read only here)
	input  wire logic        boot_vector_fuse,
	input  wire logic [15:0] boot_start_word,
	input  wire logic [7:0]  fuse_low,
	input  wire logic [7:0]  lock_bits,
	input  wire logic [15:0] halting_base_word,
	// Flash macro side
	output logic             flash_erase,
	output logic             flash_write,
	output logic             flash_lock,
	output logic             flash_fill,
	output logic             flash_discard,
	output logic      [15:0] flash_word_addr,
	output logic      [15:0] flash_data,
	input  wire logic        flash_done
);

	// ****************************************
	// State
	// ****************************************
	fsp_pkg::fsp_state_e state;
	logic                ready_irq_enable;
	logic                section_busy;
	logic                section_read_reenable;
	logic                lock_set;
	logic                page_write_cmd;
	logic                page_erase_cmd;
	logic                store_enable;
	logic                pointer_bit16;
	logic                loading;
	logic                store_open;
	logic                load_open;
	logic                cmd_write;
	logic [4:0]          wcmd;
	logic [16:0]         zptr;
	logic [15:0]         zword;
	logic                in_halting;
	logic                store_go;

	assign wcmd      = ctrl_wdata[4:0];
	// Command writes while an erase, write or lock programming runs are dropped (bit 7 still lands) so the
	// latched operation cannot be disturbed
	assign cmd_write = ctrl_wr && (state != fsp_pkg::FSP_BUSY) && (state != fsp_pkg::FSP_LOCKW) &&
		(wcmd == fsp_pkg::CMD_REEN || wcmd == fsp_pkg::CMD_LOCK || wcmd == fsp_pkg::CMD_PGWR ||
		wcmd == fsp_pkg::CMD_PGER || wcmd == fsp_pkg::CMD_FILL); // [RULE19]
	assign zptr       = {pointer_bit16, pointer_high, pointer_low}; // [RULE20]
	assign zword      = zptr[16:1];
	assign in_halting = (zword >= halting_base_word);
	assign store_go   = store_program_instruction && store_open && (state == fsp_pkg::FSP_ARMED);

	// ****************************************
	// Arming windows
	// ****************************************
	fsp_window u_store_win
	(
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.start    (cmd_write),
		.stop     (store_go),
		.length   (fsp_pkg::STORE_WINDOW), // [RULE17]
		.open_now (store_open)
	);

	fsp_window u_load_win
	(
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.start    (cmd_write && wcmd == fsp_pkg::CMD_LOCK),
		.stop     (load_program_instruction),
		.length   (fsp_pkg::LOAD_WINDOW), // [RULE11]
		.open_now (load_open)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= fsp_pkg::FSP_IDLE;
		else
			case (state)
				fsp_pkg::FSP_IDLE:
					if (cmd_write)
						state <= fsp_pkg::FSP_ARMED;
				fsp_pkg::FSP_ARMED:
					if (store_go && (page_erase_cmd || page_write_cmd))
						state <= fsp_pkg::FSP_BUSY;
					else if (store_go && lock_set)
						state <= fsp_pkg::FSP_LOCKW;
					else if (store_go || (!store_open && !cmd_write))
						state <= fsp_pkg::FSP_IDLE;
				fsp_pkg::FSP_BUSY:
					if (flash_done)
						state <= fsp_pkg::FSP_IDLE; // [RULE13] [RULE15]
				fsp_pkg::FSP_LOCKW:
					if (flash_done)
						state <= fsp_pkg::FSP_IDLE; // [RULE10]
				default:
					state <= fsp_pkg::FSP_IDLE;
			endcase
	end

	// ****************************************
	// Command bits
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			section_read_reenable <= 1'b0;
			lock_set              <= 1'b0;
			page_write_cmd        <= 1'b0;
			page_erase_cmd        <= 1'b0;
			store_enable          <= 1'b0;
		end
		else if (cmd_write)
		begin
			section_read_reenable <= ctrl_wdata[fsp_pkg::BIT_REEN];
			lock_set              <= ctrl_wdata[fsp_pkg::BIT_LOCK];
			page_write_cmd        <= ctrl_wdata[fsp_pkg::BIT_PGWR];
			page_erase_cmd        <= ctrl_wdata[fsp_pkg::BIT_PGER];
			store_enable          <= 1'b1; // [RULE17]
		end
		else if (state == fsp_pkg::FSP_ARMED && (store_go && (page_erase_cmd || page_write_cmd)))
			store_enable <= 1'b1; // [RULE18]
		else if ((state == fsp_pkg::FSP_BUSY || state == fsp_pkg::FSP_LOCKW) && !flash_done)
			store_enable <= 1'b1; // [RULE18]
		else if (state != fsp_pkg::FSP_LOCKW && (state == fsp_pkg::FSP_ARMED) && (store_go ||
			(!store_open && !(lock_set && load_open))))
		begin
			section_read_reenable <= 1'b0;
			lock_set              <= store_go ? lock_set : 1'b0; // [RULE10]
			page_write_cmd        <= (store_go && page_write_cmd); // [RULE13]
			page_erase_cmd        <= (store_go && page_erase_cmd); // [RULE15]
			store_enable          <= 1'b0;
		end
		else if (flash_done || state == fsp_pkg::FSP_IDLE)
		begin
			section_read_reenable <= 1'b0;
			lock_set              <= 1'b0; // [RULE10]
			page_write_cmd        <= 1'b0; // [RULE13]
			page_erase_cmd        <= 1'b0; // [RULE15]
			store_enable          <= 1'b0; // [RULE17]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ready_irq_enable <= 1'b0;
		else if (ctrl_wr)
			ready_irq_enable <= ctrl_wdata[fsp_pkg::BIT_IRQ_EN];
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			pointer_bit16 <= 1'b0;
		else if (ext_wr)
			pointer_bit16 <= ext_wdata[0]; // [RULE20]
	end

	// ****************************************
	// Section busy and buffer loading
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			section_busy <= 1'b0;
		else if (store_go && (page_erase_cmd || page_write_cmd) && !in_halting)
			section_busy <= 1'b1; // [RULE4]
		else if (store_go && section_read_reenable)
			section_busy <= 1'b0; // [RULE5] [RULE6]
		else if (store_go && wcmd_is_fill(lock_set, page_write_cmd, page_erase_cmd, section_read_reenable))
			section_busy <= 1'b0; // [RULE5]
	end

	function automatic logic wcmd_is_fill(input logic a, input logic b, input logic c, input logic d);
		wcmd_is_fill = !(a || b || c || d);
	endfunction : wcmd_is_fill

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			loading <= 1'b0;
		else if (cmd_write && wcmd == fsp_pkg::CMD_REEN)
			loading <= 1'b0; // [RULE7]
		else if (store_go && wcmd_is_fill(lock_set, page_write_cmd, page_erase_cmd, section_read_reenable))
			loading <= 1'b1;
		else if (state == fsp_pkg::FSP_BUSY && flash_done && page_write_cmd)
			loading <= 1'b0;
	end

	// ****************************************
	// Flash macro strobes, latched address
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flash_erase     <= 1'b0;
			flash_write     <= 1'b0;
			flash_lock      <= 1'b0;
			flash_fill      <= 1'b0;
			flash_discard   <= 1'b0;
			flash_word_addr <= 16'h0000;
			flash_data      <= 16'h0000;
			cpu_halt        <= 1'b0;
		end
		else
		begin
			flash_erase   <= store_go && page_erase_cmd; // [RULE14]
			flash_write   <= store_go && page_write_cmd; // [RULE12]
			flash_lock    <= store_go && lock_set; // [RULE9]
			flash_fill    <= store_go && wcmd_is_fill(lock_set, page_write_cmd, page_erase_cmd,
				section_read_reenable); // [RULE16]
			flash_discard <= cmd_write && wcmd == fsp_pkg::CMD_REEN && (loading || store_go); // [RULE7]
			if (store_go)
			begin
				flash_word_addr <= zword; // [RULE21] [RULE16]
				flash_data      <= lock_set ? {8'h00, data_low_reg} : {data_high_reg, data_low_reg}; // [RULE9]
			end
			if (store_go && (page_erase_cmd || page_write_cmd) && in_halting)
				cpu_halt <= 1'b1; // [RULE13] [RULE15]
			else if (flash_done)
				cpu_halt <= 1'b0;
		end
	end

	// ****************************************
	// Readback, interrupt, reset vector
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			load_hit  <= 1'b0;
			load_data <= 8'h00;
		end
		else
		begin
			load_hit <= load_program_instruction && load_open && lock_set && store_enable; // [RULE11]
			if (load_program_instruction && load_open && lock_set)
				load_data <= zptr[0] ? lock_bits : fuse_low; // [RULE11] [RULE22]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ready_irq       <= 1'b0;
			section_blocked <= 1'b0;
			reset_word      <= fsp_pkg::APP_RESET_WORD;
			self_program_control_status <= fsp_pkg::CTRL_RESET;
			program_pointer_extension   <= fsp_pkg::EXT_RESET;
		end
		else
		begin
			ready_irq       <= ready_irq_enable && global_irq_en && !store_enable; // [RULE3]
			section_blocked <= section_busy; // [RULE4]
			// Fuse is only sampled; no path here can change it
			reset_word      <= boot_vector_fuse ? fsp_pkg::APP_RESET_WORD : boot_start_word; // [RULE1] [RULE2]
			self_program_control_status <= {ready_irq_enable, section_busy, 1'b0, section_read_reenable,
				lock_set, page_write_cmd, page_erase_cmd, store_enable}; // [RULE8]
			program_pointer_extension   <= {7'h00, pointer_bit16};
		end
	end

endmodule : fsp_control

/* File: testbench/fsp_control_asserts.sv */
// Concurrent checks on the flash self-program control ports.
// Assumes it is bound to fsp_control and sees one clock domain.
module fsp_control_asserts
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Register side
	input wire logic [7:0]  self_program_control_status,
	input wire logic [7:0]  program_pointer_extension,
	// Instruction side
	input wire logic        store_program_instruction,
	input wire logic [7:0]  pointer_high,
	input wire logic [7:0]  pointer_low,
	input wire logic [7:0]  data_low_reg,
	input wire logic [7:0]  data_high_reg,
	// Flash side
	input wire logic        flash_erase,
	input wire logic        flash_write,
	input wire logic        flash_lock,
	input wire logic        flash_fill,
	input wire logic [15:0] flash_word_addr,
	input wire logic [15:0] flash_data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [7:0]  st;
	logic [15:0] zword;
	assign st = self_program_control_status;
	// Word address drops the byte select bit
	assign zword = {program_pointer_extension[0], pointer_high, pointer_low[7:1]};
	// ****************************************
	// Properties
	// ****************************************
	AST_RSVD_ZERO: assert property (st[5] == 1'b0) else $error("reserved bit set");
	AST_EXT_FORM: assert property (program_pointer_extension[7:1] == 7'h00) else $error("ext upper bits");
	AST_ERASE: assert property (flash_erase |-> $past(store_program_instruction) && st[1] && st[0])
		else $error("erase without armed store");
	AST_WRITE: assert property (flash_write |-> $past(store_program_instruction) && st[2] && st[0])
		else $error("write without armed store");
	AST_LOCK: assert property (flash_lock |-> st[3] && flash_data[7:0] == $past(data_low_reg))
		else $error("lock data wrong");
	AST_FILL: assert property (flash_fill |-> flash_word_addr == $past(zword) &&
		flash_data == $past({data_high_reg, data_low_reg})) else $error("fill word wrong");
	AST_PAGE_ADDR: assert property (flash_erase || flash_write |-> flash_word_addr == $past(zword))
		else $error("page address wrong");
	AST_STEN_HOLD: assert property (flash_erase || flash_write |=> st[0] [*3])
		else $error("store enable dropped early");
	AST_ONE_STROBE: assert property ($onehot0({flash_erase, flash_write, flash_lock, flash_fill}))
		else $error("two strobes at once");
endmodule : fsp_control_asserts

bind fsp_control fsp_control_asserts chk_u (.ref_clk, .sys_rst, .self_program_control_status,
	.program_pointer_extension, .store_program_instruction, .pointer_high, .pointer_low, .data_low_reg,
	.data_high_reg, .flash_erase, .flash_write, .flash_lock, .flash_fill, .flash_word_addr, .flash_data);

/* File: testbench/fsp_cpu_model.sv */
// CPU core and flash macro stand-in for the self-program control block.
// Assumes the bench calls issue from one process, on the block clock.
module fsp_cpu_model
#(
	parameter int DONE_CYCLES = 8
)
(
	// Clock
	input wire logic ref_clk,
	// Instruction pulses
	output logic     store_program_instruction,
	output logic     load_program_instruction,
	// Flash macro
	input wire logic flash_erase,
	input wire logic flash_write,
	input wire logic flash_lock,
	output logic     flash_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int busy_cnt = 0;
	initial
	begin
		store_program_instruction = 1'b0;
		load_program_instruction = 1'b0;
		flash_done = 1'b0;
	end
	// ****************************************
	// Instruction issue and flash completion
	// ****************************************
	// Issued at the next edge, so it lands within the arming window
	task automatic issue(input logic is_load);
		@(posedge ref_clk);
		if (is_load)
			load_program_instruction <= 1'b1;
		else
			store_program_instruction <= 1'b1;
		@(posedge ref_clk);
		load_program_instruction <= 1'b0;
		store_program_instruction <= 1'b0;
	endtask : issue
	// Slow enough that the block must hold its state across the operation
	always @(posedge ref_clk)
	begin
		flash_done <= 1'b0;
		if (flash_erase || flash_write || flash_lock)
			busy_cnt <= DONE_CYCLES;
		else if (busy_cnt > 0)
		begin
			busy_cnt <= busy_cnt - 1;
			flash_done <= (busy_cnt == 1);
		end
	end
endmodule : fsp_cpu_model

/* File: testbench/testbench.sv */
// Self-checking bench for the flash self-program control block.
// Assumes the design, the CPU model and the bound checker compile beside it.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 27735;
	int num_errors = 0;
	int check_count = 0;
	logic ref_clk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0, ext_wr = 1'b0, global_irq_en = 1'b0;
	logic boot_vector_fuse = 1'b1;
	int discard_count = 0;
	logic [15:0] erase_ptr = 16'h0000;
	// Reference model: fill words queued in issue order, popped at each fill strobe
	logic [31:0] fill_q[$];
	logic [31:0] fill_exp;
	logic [7:0] ctrl_wdata = 8'h00, ext_wdata = 8'h00, pointer_high = 8'h00, pointer_low = 8'h00;
	logic [7:0] data_low_reg = 8'h00, data_high_reg = 8'h00, fuse_low = 8'h00, lock_bits = 8'h00;
	logic [7:0] self_program_control_status, program_pointer_extension, load_data, st;
	logic ready_irq, load_hit, cpu_halt, section_blocked, flash_erase, flash_write, flash_lock;
	logic flash_fill, flash_discard, flash_done, store_program_instruction, load_program_instruction;
	logic [15:0] reset_word, flash_word_addr, flash_data;
	assign st = self_program_control_status;
	initial forever #10 ref_clk = ~ref_clk;
	fsp_control dut_u (.ref_clk, .sys_rst, .ctrl_wr, .ctrl_wdata, .self_program_control_status, .ext_wr,
		.ext_wdata, .program_pointer_extension, .global_irq_en, .store_program_instruction,
		.load_program_instruction, .pointer_high, .pointer_low, .data_low_reg, .data_high_reg, .ready_irq,
		.load_hit, .load_data, .cpu_halt, .section_blocked, .reset_word, .boot_vector_fuse,
		.boot_start_word(16'h7000), .fuse_low, .lock_bits, .halting_base_word(16'h8000), .flash_erase,
		.flash_write, .flash_lock, .flash_fill, .flash_discard, .flash_word_addr, .flash_data, .flash_done);
	fsp_cpu_model #(.DONE_CYCLES(8)) cpu_u (.ref_clk, .store_program_instruction, .load_program_instruction,
		.flash_erase, .flash_write, .flash_lock, .flash_done);
	always @(posedge ref_clk)
		if (flash_discard === 1'b1)
			discard_count <= discard_count + 1;
	always @(posedge ref_clk)
		if (flash_fill === 1'b1)
		begin
			if (fill_q.size() == 0)
				chk(16'h0001, 16'h0000);
			else
			begin
				fill_exp = fill_q.pop_front();
				chk(flash_word_addr, fill_exp[31:16]);
				chk(flash_data, fill_exp[15:0]);
			end
		end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic wr_ctrl(input logic [7:0] v);
		@(posedge ref_clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= v;
		@(posedge ref_clk);
		ctrl_wr <= 1'b0;
	endtask : wr_ctrl
	// Order of bits: erase, write, lock, fill, load answer
	task automatic expect_strobe(input logic [4:0] exp);
		logic [4:0] got;
		#1;
		got = {flash_erase, flash_write, flash_lock, flash_fill, load_hit};
		for (int i = 0; i < 4 && got == 5'h00; i++)
		begin
			@(posedge ref_clk);
			#1;
			got = {flash_erase, flash_write, flash_lock, flash_fill, load_hit};
		end
		chk(16'(got), 16'(exp));
		if (exp == 5'h01)
			chk(16'(load_data), 16'(pointer_low[0] ? lock_bits : fuse_low));
	endtask : expect_strobe
	task automatic op(input logic [4:0] cmd, input logic [4:0] exp, input logic ext);
		logic [15:0] addr;
		@(posedge ref_clk);
		ext_wr <= 1'b1;
		ext_wdata <= {7'h00, ext};
		// A page write reuses the page of the erase before it
		if (cmd == fsp_pkg::CMD_PGWR)
			{pointer_high, pointer_low} <= erase_ptr;
		else
			{pointer_high, pointer_low} <= 16'($random(seed));
		data_low_reg <= 8'($random(seed));
		data_high_reg <= 8'($random(seed));
		@(posedge ref_clk);
		ext_wr <= 1'b0;
		addr = {ext, pointer_high, pointer_low[7:1]};
		if (cmd == fsp_pkg::CMD_PGER)
			erase_ptr = {pointer_high, pointer_low};
		if (exp == 5'h02)
			fill_q.push_back({addr, data_high_reg, data_low_reg});
		wr_ctrl({3'h0, cmd});
		cpu_u.issue(exp == 5'h01);
		expect_strobe(exp);
		chk(16'(program_pointer_extension), 16'(ext));
		if (exp[4:3] != 2'h0)
		begin
			settle();
			chk(16'({st[6], section_blocked, cpu_halt, st[0]}), 16'({!ext, !ext, ext, 1'b1}));
			chk(16'(cpu_halt), 16'(ext));
		end
		if (exp[4:2] != 3'h0)
		begin
			// Nothing new is started before the running operation ends
			for (int i = 0; i < 20 && flash_done !== 1'b1; i++)
			begin
				@(posedge ref_clk);
				#1;
			end
			chk(16'(flash_done), 16'h0001);
			settle();
			chk(16'({st[3:0], cpu_halt}), 16'h0000);
		end
	endtask : op
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		fuse_low = 8'($random(seed));
		lock_bits = 8'($random(seed));
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		settle();
		chk(16'(st), 16'h0000);
		chk(reset_word, 16'h0000);
		@(posedge ref_clk);
		boot_vector_fuse <= 1'b0;
		settle();
		chk(reset_word, 16'h7000);
		op(fsp_pkg::CMD_FILL, 5'h02, 1'b0);
		op(fsp_pkg::CMD_PGER, 5'h10, 1'b0);
		op(fsp_pkg::CMD_FILL, 5'h02, 1'b0);
		settle();
		chk(16'(st[6]), 16'h0000);
		op(fsp_pkg::CMD_PGWR, 5'h08, 1'b0);
		// Buffer already emptied by the page write: re-enable only, no discard
		wr_ctrl({3'h0, fsp_pkg::CMD_REEN});
		cpu_u.issue(1'b0);
		settle();
		chk(16'({st[6], section_blocked}), 16'h0000);
		chk(16'(discard_count), 16'h0000);
		// Buffer holds a word now, so the re-enable write must discard it
		op(fsp_pkg::CMD_FILL, 5'h02, 1'b0);
		wr_ctrl({3'h0, fsp_pkg::CMD_REEN});
		cpu_u.issue(1'b0);
		settle();
		chk(16'(discard_count), 16'h0001);
		op(fsp_pkg::CMD_PGER, 5'h10, 1'b1);
		op(fsp_pkg::CMD_PGWR, 5'h08, 1'b1);
		op(fsp_pkg::CMD_LOCK, 5'h04, 1'b0);
		for (int i = 0; i < 6; i++)
			op(fsp_pkg::CMD_LOCK, 5'h01, 1'b0);
		wr_ctrl({3'h0, fsp_pkg::CMD_FILL});
		repeat (6) @(posedge ref_clk);
		cpu_u.issue(1'b0);
		expect_strobe(5'h00);
		chk(16'(st[0]), 16'h0000);
		wr_ctrl({3'h0, fsp_pkg::CMD_LOCK});
		repeat (6) @(posedge ref_clk);
		#1;
		chk(16'(st[3:0]), 16'h0000);
		for (int c = 0; c < 32; c++)
			if (!(c inside {17, 9, 5, 3, 1}))
			begin
				wr_ctrl(8'(c));
				settle();
				chk(16'(st[4:0]), 16'h0000);
			end
		@(posedge ref_clk);
		global_irq_en <= 1'b1;
		wr_ctrl(8'h80);
		settle();
		chk(16'(ready_irq), 16'h0001);
		wr_ctrl(8'h81);
		settle();
		chk(16'(ready_irq), 16'h0000);
		repeat (6) @(posedge ref_clk);
		#1;
		chk(16'(ready_irq), 16'h0001);
		chk(16'(fill_q.size()), 16'h0000);
		close_out();
	end
	initial
	begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule : testbench
